// *** common/iem_params.svh ***
// Register offsets, field positions and reset values of the interrupt enable mask.
`ifndef IEM_PARAMS_SVH
`define IEM_PARAMS_SVH

`define IEM_ADDR_W          12
`define IEM_IE_OFFSET       12'h0A8
`define IEM_STATUS_OFFSET   12'h0AC
`define IEM_MASK_OFFSET     12'h0B0
`define IEM_PEND_OFFSET     12'h0B4

`define IEM_IE_RESET        8'h00
`define IEM_STATUS_RESET    7'h00
`define IEM_MASK_RESET      7'h00

`define IEM_GLOBAL_BIT      7
`define IEM_SPI_BIT         6
`define IEM_TIMER2_BIT      5
`define IEM_UART_BIT        4
`define IEM_TIMER1_BIT      3
`define IEM_EXT1_BIT        2
`define IEM_TIMER0_BIT      1
`define IEM_EXT0_BIT        0
`define IEM_NUM_SRC         7

`define IEM_RESP_OKAY       2'h0
`define IEM_RESP_SLVERR     2'h2

`endif

// *** common/iem_pkg.sv ***
// Types shared by the interrupt enable mask and its bus slave.
package iem_pkg;
  typedef logic [11:0] iem_addr_t;
  typedef logic [31:0] iem_word_t;
  typedef logic [7:0]  iem_byte_t;
  typedef logic [6:0]  iem_src_vec_t;
endpackage

// *** common/iem_regs_if.sv ***
// Register access strobes passed from the bus slave to the register file.
`timescale 1ns/1ps
interface iem_regs_if;
  logic              wr_stb;
  iem_pkg::iem_addr_t wr_addr;
  iem_pkg::iem_word_t wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  iem_pkg::iem_addr_t rd_addr;
  iem_pkg::iem_word_t rd_data;
  logic              rd_hit;

  modport bus  (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface

// *** hdl/iem_axil_slave.sv ***
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/1ps
`include "iem_params.svh"
module iem_axil_slave (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // Write address and data channels
  input  wire iem_pkg::iem_addr_t s_axil_awaddr,
  input  wire logic               s_axil_awvalid,
  output logic                    s_axil_awready,
  input  wire iem_pkg::iem_word_t s_axil_wdata,
  input  wire logic [3:0]         s_axil_wstrb,
  input  wire logic               s_axil_wvalid,
  output logic                    s_axil_wready,
  // Write response channel
  output logic [1:0]              s_axil_bresp,
  output logic                    s_axil_bvalid,
  input  wire logic               s_axil_bready,
  // Read channels
  input  wire iem_pkg::iem_addr_t s_axil_araddr,
  input  wire logic               s_axil_arvalid,
  output logic                    s_axil_arready,
  output iem_pkg::iem_word_t      s_axil_rdata,
  output logic [1:0]              s_axil_rresp,
  output logic                    s_axil_rvalid,
  input  wire logic               s_axil_rready,
  // Register side
  iem_regs_if.bus                 regs
);
  import iem_pkg::*;

  logic      aw_held_reg;
  logic      w_held_reg;
  iem_addr_t awaddr_reg;
  iem_word_t wdata_reg;
  logic [3:0] wstrb_reg;
  logic      aw_fire;
  logic      w_fire;
  logic      ar_fire;
  logic      wr_go;

  // Address and data are taken in either order and held until both are in.
  assign s_axil_awready = !aw_held_reg && !s_axil_bvalid;
  assign s_axil_wready  = !w_held_reg && !s_axil_bvalid;
  assign s_axil_arready = !s_axil_rvalid;
  assign aw_fire        = s_axil_awvalid && s_axil_awready;
  assign w_fire         = s_axil_wvalid && s_axil_wready;
  assign ar_fire        = s_axil_arvalid && s_axil_arready;
  assign wr_go          = aw_held_reg && w_held_reg && !s_axil_bvalid;

  assign regs.wr_stb  = wr_go;
  assign regs.wr_addr = awaddr_reg;
  assign regs.wr_data = wdata_reg;
  assign regs.wr_strb = wstrb_reg;
  assign regs.rd_addr = s_axil_araddr;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axil_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axil_wdata;
        wstrb_reg  <= s_axil_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= `IEM_RESP_OKAY;
    end else if (wr_go) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp  <= regs.wr_hit ? `IEM_RESP_OKAY : `IEM_RESP_SLVERR;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // Reads have no side effects, so the data is captured straight from the decode.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h00000000;
      s_axil_rresp  <= `IEM_RESP_OKAY;
    end else if (ar_fire) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata  <= regs.rd_data;
      s_axil_rresp  <= regs.rd_hit ? `IEM_RESP_OKAY : `IEM_RESP_SLVERR;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end
endmodule

// *** hdl/iem_top.sv ***
// Interrupt enable mask with global gate, per-source gates and event status.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "iem_params.svh"
module iem_top (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // AXI4-Lite write address and data
  input  wire iem_pkg::iem_addr_t s_axil_awaddr,
  input  wire logic               s_axil_awvalid,
  output logic                    s_axil_awready,
  input  wire iem_pkg::iem_word_t s_axil_wdata,
  input  wire logic [3:0]         s_axil_wstrb,
  input  wire logic               s_axil_wvalid,
  output logic                    s_axil_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axil_bresp,
  output logic                    s_axil_bvalid,
  input  wire logic               s_axil_bready,
  // AXI4-Lite read
  input  wire iem_pkg::iem_addr_t s_axil_araddr,
  input  wire logic               s_axil_arvalid,
  output logic                    s_axil_arready,
  output iem_pkg::iem_word_t      s_axil_rdata,
  output logic [1:0]              s_axil_rresp,
  output logic                    s_axil_rvalid,
  input  wire logic               s_axil_rready,
  // Pending requests from peripherals on the same clock
  input  wire logic               ext_input0_req,
  input  wire logic               timer0_overflow_flag,
  input  wire logic               ext_input1_req,
  input  wire logic               timer1_overflow_flag,
  input  wire logic               serial_async_port_req,
  input  wire logic               timer2_low_overflow_flag,
  input  wire logic               timer2_high_overflow_flag,
  input  wire logic               serial_sync_port_req,
  // Toward the interrupt sequencer
  output iem_pkg::iem_src_vec_t   irq_pending,
  output logic                    irq_out
);
  import iem_pkg::*;

  iem_regs_if regs_if ();

  iem_axil_slave u_slave (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .regs           (regs_if.bus)
  );

  // Register state.
  iem_byte_t    interrupt_enable_reg;
  iem_byte_t    interrupt_enable_next;
  iem_src_vec_t pending_reg;
  iem_src_vec_t pending_next;
  iem_src_vec_t status_reg;
  iem_src_vec_t status_next;
  iem_src_vec_t mask_reg;
  iem_src_vec_t mask_next;

  // Decode and selection.
  iem_src_vec_t raw_req;
  iem_src_vec_t src_enables;
  logic         global_irq_enable;
  logic         spi_port_irq_enable;
  logic         timer2_irq_enable;
  logic         uart_irq_enable;
  logic         timer1_irq_enable;
  logic         ext_input1_irq_enable;
  logic         timer0_irq_enable;
  logic         ext_input0_irq_enable;
  logic         wr_low_byte;
  logic         wr_ie;
  logic         wr_status;
  logic         wr_mask;
  iem_src_vec_t status_clear;
  iem_src_vec_t new_events;

  // Address match shared by the read and write paths.
  function automatic logic addr_is(input iem_addr_t addr, input iem_addr_t offset);
    addr_is = (addr == offset);
  endfunction

  function automatic logic addr_hit(input iem_addr_t addr);
    addr_hit = addr_is(addr, `IEM_IE_OFFSET) || addr_is(addr, `IEM_STATUS_OFFSET) ||
               addr_is(addr, `IEM_MASK_OFFSET) || addr_is(addr, `IEM_PEND_OFFSET);
  endfunction

  assign global_irq_enable     = interrupt_enable_reg[`IEM_GLOBAL_BIT];
  assign spi_port_irq_enable   = interrupt_enable_reg[`IEM_SPI_BIT];
  assign timer2_irq_enable     = interrupt_enable_reg[`IEM_TIMER2_BIT];
  assign uart_irq_enable       = interrupt_enable_reg[`IEM_UART_BIT];
  assign timer1_irq_enable     = interrupt_enable_reg[`IEM_TIMER1_BIT];
  assign ext_input1_irq_enable = interrupt_enable_reg[`IEM_EXT1_BIT];
  assign timer0_irq_enable     = interrupt_enable_reg[`IEM_TIMER0_BIT];
  assign ext_input0_irq_enable = interrupt_enable_reg[`IEM_EXT0_BIT];

  // Either half of timer 2 raises the one timer 2 request.
  assign raw_req[`IEM_TIMER2_BIT] = timer2_low_overflow_flag | timer2_high_overflow_flag;
  assign raw_req[`IEM_SPI_BIT]    = serial_sync_port_req;
  assign raw_req[`IEM_UART_BIT]   = serial_async_port_req;
  assign raw_req[`IEM_TIMER1_BIT] = timer1_overflow_flag;
  assign raw_req[`IEM_EXT1_BIT]   = ext_input1_req;
  assign raw_req[`IEM_TIMER0_BIT] = timer0_overflow_flag;
  assign raw_req[`IEM_EXT0_BIT]   = ext_input0_req;

  // Per-source gates, each one bit of the enable register.
  assign src_enables = {spi_port_irq_enable, timer2_irq_enable, uart_irq_enable,
                        timer1_irq_enable, ext_input1_irq_enable, timer0_irq_enable,
                        ext_input0_irq_enable};

  // The global bit overrides every per-source gate.
  assign pending_next = global_irq_enable ? (raw_req & src_enables) : 7'h00;

  // Register writes; all writable registers are one byte wide, so only lane 0 counts.
  assign wr_low_byte = regs_if.wr_stb && regs_if.wr_strb[0];
  assign wr_ie       = wr_low_byte && addr_is(regs_if.wr_addr, `IEM_IE_OFFSET);
  assign wr_status   = wr_low_byte && addr_is(regs_if.wr_addr, `IEM_STATUS_OFFSET);
  assign wr_mask     = wr_low_byte && addr_is(regs_if.wr_addr, `IEM_MASK_OFFSET);
  assign regs_if.wr_hit = addr_hit(regs_if.wr_addr);

  assign interrupt_enable_next = wr_ie ? regs_if.wr_data[7:0] : interrupt_enable_reg;
  assign mask_next             = wr_mask ? regs_if.wr_data[6:0] : mask_reg;

  // A source that newly gets through is an event; set beats a same-cycle clear.
  assign status_clear = wr_status ? regs_if.wr_data[6:0] : 7'h00;
  assign new_events   = pending_next & ~pending_reg;
  assign status_next  = (status_reg & ~status_clear) | new_events;

  assign regs_if.rd_hit  = addr_hit(regs_if.rd_addr);
  assign regs_if.rd_data =
    addr_is(regs_if.rd_addr, `IEM_IE_OFFSET)     ? {24'h000000, interrupt_enable_reg} :
    addr_is(regs_if.rd_addr, `IEM_STATUS_OFFSET) ? {25'h0, status_reg} :
    addr_is(regs_if.rd_addr, `IEM_MASK_OFFSET)   ? {25'h0, mask_reg} :
    addr_is(regs_if.rd_addr, `IEM_PEND_OFFSET)   ? {17'h0, raw_req, 1'b0, pending_reg} :
    32'h00000000;

  // The masked view is re-sampled on every edge so enable changes act at once.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_enable_reg <= `IEM_IE_RESET;
      pending_reg          <= 7'h00;
      status_reg           <= `IEM_STATUS_RESET;
      mask_reg             <= `IEM_MASK_RESET;
    end else begin
      interrupt_enable_reg <= interrupt_enable_next;
      pending_reg          <= pending_next;
      status_reg           <= status_next;
      mask_reg             <= mask_next;
    end
  end

  assign irq_pending = pending_reg;
  assign irq_out     = |(status_reg & mask_reg);

  // Checks on the gating path.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_gate_open;
    global_irq_enable && ((raw_req & src_enables) != 7'h00);
  endsequence

  sequence s_seen_next;
    ##1 (pending_reg != 7'h00);
  endsequence

  chk_global_off_blocks: assert property (
    !global_irq_enable |=> (pending_reg == 7'h00))
    else $error("Request passed while global enable was clear.");

  chk_global_on_pass: assert property (
    global_irq_enable |=> (pending_reg == $past(raw_req & src_enables)))
    else $error("Enabled request not passed under global enable.");

  chk_timer2_both_halves: assert property (
    (global_irq_enable && timer2_irq_enable &&
     (timer2_low_overflow_flag || timer2_high_overflow_flag))
    |=> pending_reg[`IEM_TIMER2_BIT])
    else $error("Timer 2 overflow not passed.");

  chk_uart_gate: assert property (
    $rose(pending_reg[`IEM_UART_BIT]) |-> $past(uart_irq_enable && serial_async_port_req))
    else $error("UART request passed while masked.");

  chk_timer1_gate: assert property (
    !timer1_irq_enable |=> !pending_reg[`IEM_TIMER1_BIT])
    else $error("Timer 1 request passed while masked.");

  chk_other_source_gates: assert property (
    (pending_reg & ~$past(src_enables) & 7'h47) == 7'h00)
    else $error("SPI, external or timer 0 request passed while masked.");

  chk_sample_each_cycle: assert property (
    s_gate_open |-> s_seen_next)
    else $error("Open request not sampled on the next edge.");

  chk_status_sticky_set: assert property (
    (pending_reg != 7'h00) |-> ((status_reg & pending_reg & ~$past(pending_reg)) ==
                                (pending_reg & ~$past(pending_reg))))
    else $error("New masked request did not set its status bit.");

  chk_irq_follows_status: assert property (
    ((status_reg & mask_reg) != 7'h00) |-> irq_out ##1 ((status_reg & mask_reg) != 7'h00 || !irq_out))
    else $error("Interrupt output does not follow unmasked status.");

  // A lost enable write would silently leave every source gated the old way.
  chk_enable_write_lands: assert property (
    wr_ie |=> (interrupt_enable_reg == $past(regs_if.wr_data[7:0])))
    else $error("Enable register did not take the written byte.");

  chk_enable_holds: assert property (
    !wr_ie |=> $stable(interrupt_enable_reg))
    else $error("Enable register changed without a write.");

  chk_mask_write_lands: assert property (
    wr_mask |=> (mask_reg == $past(regs_if.wr_data[6:0])))
    else $error("Mask register did not take the written bits.");

  // A new event in the same cycle keeps its bit, so only the others must clear.
  chk_status_w1c: assert property (
    wr_status |=> ((status_reg & $past(status_clear) & ~$past(new_events)) == 7'h00))
    else $error("Written status bits were not cleared.");
endmodule

// *** dv/iem_seq_model.sv ***
// Interrupt sequencer stand-in that samples the masked requests every clock.
`timescale 1ns/1ps
module iem_seq_model (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Masked requests from the enable stage
  input  wire iem_pkg::iem_src_vec_t irq_pending,
  // Decoded request
  output logic                       req_seen,
  output logic [2:0]                 req_index
);
  import iem_pkg::*;
  // The lowest index wins, as in the fixed order used when priority levels tie.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_seen  <= 1'b0;
      req_index <= 3'h0;
    end else begin
      req_seen  <= |irq_pending;
      req_index <= 3'h0;
      for (int i = 6; i >= 0; i--) begin
        if (irq_pending[i]) begin
          req_index <= i[2:0];
        end
      end
    end
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the interrupt enable mask.
`timescale 1ns/1ps
`include "iem_params.svh"
module tb;
  import iem_pkg::*;
  logic         ref_clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, irq_out, req_seen, chk_en, prev_ok;
  iem_addr_t    awaddr, araddr;
  iem_word_t    wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic [2:0]   req_index;
  logic [7:0]   src;
  logic [7:0]   en_m;
  logic [31:0]  rng;
  iem_src_vec_t irq_pending, mask_m, status_m, g_prev, raw_prev;
  int           bad_count, comparisons;

  iem_top iem_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .s_axil_awaddr(awaddr),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .ext_input0_req(src[0]), .timer0_overflow_flag(src[1]),
    .ext_input1_req(src[2]), .timer1_overflow_flag(src[3]), .serial_async_port_req(src[4]),
    .timer2_low_overflow_flag(src[5]), .timer2_high_overflow_flag(src[6]),
    .serial_sync_port_req(src[7]), .irq_pending(irq_pending), .irq_out(irq_out));
  iem_seq_model iem_seq_model_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .irq_pending(irq_pending), .req_seen(req_seen), .req_index(req_index));

  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // Timer 2 low and high flags share one source slot.
  function automatic logic [6:0] raw7(logic [7:0] s);
    return {s[7], s[5] | s[6], s[4], s[3], s[2], s[1], s[0]};
  endfunction
  function automatic logic [6:0] gate(logic [6:0] r);
    return en_m[7] ? (r & en_m[6:0]) : 7'h00;
  endfunction
  // The sequencer stand-in picks the lowest pending index.
  function automatic logic [2:0] low_idx(logic [6:0] r);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (r[i]) k = i[2:0];
    end
    return k;
  endfunction

  task automatic note(string what, logic [31:0] exp, logic [31:0] got, logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_word(string what, logic [31:0] exp, logic [31:0] got);
    note(what, exp, got, got === exp);
  endtask
  task automatic cmp_resp(string what, logic [1:0] exp, logic [1:0] got);
    note(what, {30'h0, exp}, {30'h0, got}, got === exp);
  endtask
  task automatic cmp_flag(string what, logic exp, logic got);
    note(what, {31'h0, exp}, {31'h0, got}, got === exp);
  endtask

  task automatic axi_write(iem_addr_t a, iem_word_t d, logic [3:0] s, logic [1:0] er);
    int   n;
    logic aw_ok, w_ok;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    while ((!aw_ok || !w_ok) && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge ref_clk);
      n++;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200) bad_count++;
    cmp_resp("bresp", er, bresp);
  endtask

  task automatic rd_chk(iem_addr_t a, logic [31:0] exp, logic [1:0] er);
    int n;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    if (n >= 200) bad_count++;
    cmp_word("rdata", exp, rdata);
    cmp_resp("rresp", er, rresp);
  endtask

  task automatic set_en(logic [7:0] v);
    rng = xs(rng);
    axi_write(`IEM_IE_OFFSET, {rng[31:8], v}, 4'hF, `IEM_RESP_OKAY);
    en_m = v;
  endtask

  // Sources idle before and after each burst, so enable writes never create events.
  task automatic run(int cycles, logic [7:0] pat);
    chk_en = 1'b1;
    repeat (cycles) begin
      @(posedge ref_clk);
      rng = xs(rng);
      src <= (pat != 8'h00) ? pat : rng[7:0];
    end
    @(posedge ref_clk);
    src <= 8'h00;
    repeat (3) @(posedge ref_clk);
    chk_en = 1'b0;
  endtask

  // Pending and status follow the sources seen one clock earlier.
  always @(negedge ref_clk) begin
    logic [6:0] g;
    g = gate(raw_prev);
    if (chk_en && prev_ok) begin
      cmp_word("irq_pending", {25'h0, g}, {25'h0, irq_pending});
      status_m = status_m | (g & ~g_prev);
      cmp_flag("irq_out", |(status_m & mask_m), irq_out);
      cmp_flag("req_seen", |g_prev, req_seen);
      cmp_word("req_index", {29'h0, low_idx(g_prev)}, {29'h0, req_index});
    end
    g_prev = g;
    raw_prev = raw7(src);
    prev_ok = chk_en;
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #(60000 * 10);
    bad_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] en;
    {rst_b, awvalid, wvalid, bready, arvalid, rready, chk_en, prev_ok} = 8'h00;
    {awaddr, araddr, wdata, wstrb, src, en_m} = 76'h0;
    {mask_m, status_m, g_prev, raw_prev} = 28'h0;
    rng = 32'h2DF6;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(`IEM_IE_OFFSET, 32'h0, `IEM_RESP_OKAY);
    rd_chk(`IEM_STATUS_OFFSET, 32'h0, `IEM_RESP_OKAY);
    rd_chk(`IEM_MASK_OFFSET, 32'h0, `IEM_RESP_OKAY);
    rd_chk(12'hFFC, 32'h0, `IEM_RESP_SLVERR);
    axi_write(12'hFFC, 32'hFF, 4'hF, `IEM_RESP_SLVERR);
    axi_write(`IEM_MASK_OFFSET, 32'h7F, 4'hF, `IEM_RESP_OKAY);
    mask_m = 7'h7F;
    for (int i = 0; i < 14; i++) begin
      rng = xs(rng);
      en = (i < 7) ? (8'h80 | (8'h01 << i)) : (i == 7) ? 8'h7F : (i == 8) ? 8'hFF : rng[7:0];
      set_en(en);
      rd_chk(`IEM_IE_OFFSET, {24'h0, en}, `IEM_RESP_OKAY);
      run(30, 8'h00);
    end
    set_en(8'hA0);
    run(3, 8'h20);
    run(3, 8'h40);
    set_en(8'h9F);
    run(3, 8'h60);
    rd_chk(`IEM_STATUS_OFFSET, {25'h0, status_m}, `IEM_RESP_OKAY);
    set_en(8'h00);
    axi_write(`IEM_MASK_OFFSET, 32'h0, 4'hF, `IEM_RESP_OKAY);
    mask_m = 7'h00;
    run(3, 8'hFF);
    axi_write(`IEM_STATUS_OFFSET, 32'h55, 4'hF, `IEM_RESP_OKAY);
    status_m = status_m & ~7'h55;
    rd_chk(`IEM_STATUS_OFFSET, {25'h0, status_m}, `IEM_RESP_OKAY);
    axi_write(`IEM_MASK_OFFSET, 32'h7F, 4'hF, `IEM_RESP_OKAY);
    mask_m = 7'h7F;
    run(3, 8'hFF);
    axi_write(`IEM_STATUS_OFFSET, 32'h7F, 4'hF, `IEM_RESP_OKAY);
    status_m = 7'h00;
    run(3, 8'hFF);
    axi_write(`IEM_IE_OFFSET, 32'hFF, 4'hE, `IEM_RESP_OKAY);
    rd_chk(`IEM_IE_OFFSET, 32'h0, `IEM_RESP_OKAY);
    set_en(8'hB5);
    chk_en = 1'b1;
    src <= 8'h5A;
    repeat (2) @(posedge ref_clk);
    rd_chk(`IEM_PEND_OFFSET, {17'h0, raw7(8'h5A), 1'b0, gate(raw7(8'h5A))},
           `IEM_RESP_OKAY);
    src <= 8'h00;
    repeat (3) @(posedge ref_clk);
    chk_en = 1'b0;
    rd_chk(`IEM_STATUS_OFFSET, {25'h0, status_m}, `IEM_RESP_OKAY);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    {en_m, mask_m, status_m} = 22'h0;
    rd_chk(`IEM_IE_OFFSET, 32'h0, `IEM_RESP_OKAY);
    rd_chk(`IEM_MASK_OFFSET, 32'h0, `IEM_RESP_OKAY);
    rd_chk(`IEM_STATUS_OFFSET, 32'h0, `IEM_RESP_OKAY);
    give_verdict();
  end
endmodule
